// ==== hw/motor_pwm_timebase_lock_consts.vh ====
`ifndef MOTOR_PWM_TIMEBASE_LOCK_CONSTS_VH
`define MOTOR_PWM_TIMEBASE_LOCK_CONSTS_VH

// Register indices; byte address is four times the index.
`define IDX_TIME_BASE_CONTROL     3'h0
`define IDX_TIME_BASE_COUNT       3'h1
`define IDX_TIME_BASE_PERIOD      3'h2
`define IDX_SPECIAL_EVENT_COMPARE 3'h3
`define IDX_PIN_PAIR_CONTROL      3'h4
`define IDX_FAULT_A_CONTROL       3'h5
`define IDX_FAULT_B_CONTROL       3'h6
`define IDX_UNLOCK_KEY            3'h7
`define ADDR_HIGH_ZERO_MSB        11

// Unlock keys.
`define KEY_FIRST                 16'hABCD
`define KEY_SECOND                16'h4321

// Unlock sequence states.
`define LOCK_IDLE                 2'h0
`define LOCK_GOT_FIRST            2'h1
`define LOCK_OPEN                 2'h2

// Time base control field positions.
`define TBC_ON_BIT                15
`define TBC_IDLE_HALT_BIT         13
`define TBC_POSTSCALE_MSB         7
`define TBC_POSTSCALE_LSB         4
`define TBC_PRESCALE_MSB          3
`define TBC_PRESCALE_LSB          2
`define TBC_MODE_MSB              1
`define TBC_MODE_LSB              0
`define TBC_WRITE_MASK            16'hA0FF

// Counting modes.
`define MODE_FREE_RUN             2'h0
`define MODE_SINGLE_EVENT         2'h1
`define MODE_UP_DOWN              2'h2
`define MODE_UP_DOWN_DOUBLE       2'h3

// Prescale terminal counts (period minus one).
`define PRESCALE_TC_1             6'h00
`define PRESCALE_TC_4             6'h03
`define PRESCALE_TC_16            6'h0F
`define PRESCALE_TC_64            6'h3F

// Fault control layout and reset value: all pairs enabled, latched mode.
`define FAULT_WRITE_MASK          16'h3F87
`define FAULT_RESET               16'h0007

// Cycles of clock enable after reset release before the pin strap is taken.
`define STRAP_SETTLE              2'h3

`endif

// ==== hw/motor_pwm_timebase_lock.v ====
// Summary of operation
// - Pin pair control and both fault registers ignore writes unless unlocked or unprotected.
// - Protection is active whenever the lock configuration input is one.
// - Lock configuration zero lets protected registers be written freely.
// - Unlock is key write 0xABCD immediately followed by key write 0x4321.
// - Protected write must be the next access; any other access voids unlock.
// - One unlock permits exactly one protected register write.
// - Output postscale bits 7..4 divide period events by code plus one.
// - Prescale bits 3..2 give count tick every 1, 4, 16 or 64 clocks.
// - Mode 11 up/down double events, 10 up/down, 01 single event.
// - Count register bit 15 reads direction: one down, zero up.
// - Count register bits 14..0 hold live count, software readable and writable.
// - Period register holds 15-bit period; bit 15 reads zero.
// - Special event needs compare direction bit equal to counting direction.
// - Special event needs compare value equal to count bits 14..0.
// - Cleared pin enable bit hands the pin back to general purpose I/O.
// - Pin enables after reset follow ownership strap: one gives I/O, zero generator.
// - Every reset enables both faults in latched mode on all pairs.
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "motor_pwm_timebase_lock_consts.vh"

module motor_pwm_timebase_lock (
    input  wire        mclk_i,
    input  wire        rst_i,
    input  wire        ce_i,
    // Register bus.
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output wire [31:0] prdata_o,
    output wire        pready_o,
    output wire        pslverr_o,
    // Configuration and processor state.
    input  wire        write_lock_config_i,
    input  wire        pin_owner_at_reset_i,
    input  wire        cpu_idle_i,
    // Time base state and pulses.
    output wire        count_direction_o,
    output wire [14:0] count_value_o,
    output wire        period_event_o,
    output wire        postscale_tick_o,
    output wire        special_event_o,
    // Pin and fault control.
    output wire [2:0]  pair_independent_o,
    output wire [2:0]  high_pin_enable_o,
    output wire [2:0]  low_pin_enable_o,
    output wire [15:0] fault_a_control_o,
    output wire [15:0] fault_b_control_o
);

    // Word index of a byte address.
    function [2:0] reg_index;
        input [11:0] addr;
        begin
            reg_index = addr[4:2];
        end
    endfunction

    // Mapped means aligned and in the first eight words.
    function mapped;
        input [11:0] addr;
        begin
            mapped = (addr[`ADDR_HIGH_ZERO_MSB:5] == 7'h00) && (addr[1:0] == 2'h0);
        end
    endfunction

    // Prescaler terminal count per code.
    function [5:0] prescale_tc;
        input [1:0] code;
        begin
            case (code)
                2'h0: prescale_tc = `PRESCALE_TC_1;
                2'h1: prescale_tc = `PRESCALE_TC_4;
                2'h2: prescale_tc = `PRESCALE_TC_16;
                default: prescale_tc = `PRESCALE_TC_64;
            endcase
        end
    endfunction

    // Read data latch.
    reg  [31:0] prdata_q;

    // Time base registers.
    reg  [15:0] tbc_q;
    reg  [14:0] count_q;
    reg         dir_q;
    reg  [14:0] period_q;
    reg  [15:0] compare_q;

    // Registers behind the lock.
    reg  [2:0]  pair_q;
    reg  [2:0]  high_en_q;
    reg  [2:0]  low_en_q;
    reg  [15:0] fault_a_q;
    reg  [15:0] fault_b_q;

    // Unlock sequence position.
    reg  [1:0]  lock_q;

    // Dividers and event pulses.
    reg  [5:0]  presc_q;
    reg  [3:0]  post_q;
    reg         per_evt_q;
    reg         post_tick_q;
    reg         match_q;
    reg         sev_q;

    // Strap capture after reset.
    reg  [1:0]  settle_q;
    reg         strap_done_q;

    // Two-stage synchronisers.
    reg         lock_meta_q;
    reg         lock_sync_q;
    reg         owner_meta_q;
    reg         owner_sync_q;

    // Nothing is taken while the enable is low.
    wire        access    = psel_i & penable_i & ce_i;
    wire        setup     = psel_i & ~penable_i & ce_i;
    wire        is_mapped = mapped(paddr_i);
    wire [2:0]  idx       = reg_index(paddr_i);
    wire        wr_en     = access & pwrite_i & is_mapped;
    // Pair control and both fault registers are guarded.
    wire        wr_prot   = wr_en & ((idx == `IDX_PIN_PAIR_CONTROL) |
                                     (idx == `IDX_FAULT_A_CONTROL) |
                                     (idx == `IDX_FAULT_B_CONTROL));
    // Open when protection is off or the keys just matched.
    wire        unlocked  = ~lock_sync_q | (lock_q == `LOCK_OPEN);
    wire        prot_ok   = wr_prot & unlocked;

    // Time base control decode.
    wire [1:0]  mode      = tbc_q[`TBC_MODE_MSB:`TBC_MODE_LSB];
    wire        run       = tbc_q[`TBC_ON_BIT] & ~(tbc_q[`TBC_IDLE_HALT_BIT] & cpu_idle_i);
    wire        tick      = run & (presc_q == prescale_tc(tbc_q[`TBC_PRESCALE_MSB:`TBC_PRESCALE_LSB]));
    // A period below the count ends the up count.
    wire        at_period = (count_q >= period_q);
    wire        single_done = tick & (mode == `MODE_SINGLE_EVENT) & at_period;
    wire        match_now = (compare_q[14:0] == count_q) & (compare_q[15] == dir_q);

    // No wait states.
    assign pready_o           = 1'b1;
    // Only unmapped addresses are errors.
    assign pslverr_o          = psel_i & penable_i & ~is_mapped;
    assign prdata_o           = prdata_q;
    assign count_direction_o  = dir_q;
    assign count_value_o      = count_q;
    assign period_event_o     = per_evt_q;
    assign postscale_tick_o   = post_tick_q;
    assign special_event_o    = sev_q;

    // Control fields drive the pins directly.
    assign pair_independent_o = pair_q;
    assign high_pin_enable_o  = high_en_q;
    assign low_pin_enable_o   = low_en_q;
    assign fault_a_control_o  = fault_a_q;
    assign fault_b_control_o  = fault_b_q;

    // Configuration straps come from outside the clock domain.
    // The lock may change at run time; the strap is read once.
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            // Locked until the real level arrives.
            lock_meta_q  <= 1'b1;
            lock_sync_q  <= 1'b1;
            owner_meta_q <= 1'b0;
            owner_sync_q <= 1'b0;
        end else if (ce_i) begin
            // Only the second stage feeds logic.
            lock_meta_q  <= write_lock_config_i;
            lock_sync_q  <= lock_meta_q;
            owner_meta_q <= pin_owner_at_reset_i;
            owner_sync_q <= owner_meta_q;
        end
    end

    // Read data is captured in the setup phase and presented in the access phase.
    // A write leaves the latch at zero.
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup) begin
            prdata_q <= 32'h0000_0000;
            // The key register reads as zero.
            if (is_mapped & ~pwrite_i) begin
                case (idx)
                    `IDX_TIME_BASE_CONTROL:     prdata_q[15:0] <= tbc_q;
                    `IDX_TIME_BASE_COUNT:       prdata_q[15:0] <= {dir_q, count_q};
                    `IDX_TIME_BASE_PERIOD:      prdata_q[15:0] <= {1'b0, period_q};
                    `IDX_SPECIAL_EVENT_COMPARE: prdata_q[15:0] <= compare_q;
                    `IDX_PIN_PAIR_CONTROL:      prdata_q[15:0] <= {5'h00, pair_q, 1'b0, high_en_q, 1'b0, low_en_q};
                    `IDX_FAULT_A_CONTROL:       prdata_q[15:0] <= fault_a_q;
                    `IDX_FAULT_B_CONTROL:       prdata_q[15:0] <= fault_b_q;
                    default:                    prdata_q[15:0] <= 16'h0000;
                endcase
            end
        end
    end

    // Unlock sequencer: every completed access advances or voids it.
    // The lock input only decides whether the result is used.
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            lock_q <= `LOCK_IDLE;
        end else if (access) begin
            // The first key restarts from any state.
            if (wr_en & (idx == `IDX_UNLOCK_KEY) & (pwdata_i[15:0] == `KEY_FIRST)) begin
                lock_q <= `LOCK_GOT_FIRST;
            end else if (wr_en & (idx == `IDX_UNLOCK_KEY) & (pwdata_i[15:0] == `KEY_SECOND) &
                         (lock_q == `LOCK_GOT_FIRST)) begin
                lock_q <= `LOCK_OPEN;
            end else begin
                // Reads, unmapped and other writes land here,
                // and an open lock closes after one write.
                lock_q <= `LOCK_IDLE;
            end
        end
    end

    // Protected registers and pin ownership strap.
    // Pins stay released until the strap is taken.
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pair_q       <= 3'h0;
            high_en_q    <= 3'h0;
            low_en_q     <= 3'h0;
            fault_a_q    <= `FAULT_RESET;
            fault_b_q    <= `FAULT_RESET;
            settle_q     <= 2'h0;
            strap_done_q <= 1'b0;
        end else if (ce_i) begin
            // The strap is taken once it has passed the
            // synchroniser; pair control is not writable
            // before that.
            if (~strap_done_q) begin
                settle_q <= settle_q + 2'h1;
                if (settle_q == `STRAP_SETTLE) begin
                    strap_done_q <= 1'b1;
                    high_en_q    <= {3{~owner_sync_q}};
                    low_en_q     <= {3{~owner_sync_q}};
                end
            end else if (prot_ok & (idx == `IDX_PIN_PAIR_CONTROL)) begin
                pair_q    <= pwdata_i[10:8];
                high_en_q <= pwdata_i[6:4];
                low_en_q  <= pwdata_i[2:0];
            end
            // A fault is cleared by writing zero.
            if (prot_ok & (idx == `IDX_FAULT_A_CONTROL)) begin
                fault_a_q <= pwdata_i[15:0] & `FAULT_WRITE_MASK;
            end
            if (prot_ok & (idx == `IDX_FAULT_B_CONTROL)) begin
                fault_b_q <= pwdata_i[15:0] & `FAULT_WRITE_MASK;
            end
        end
    end

    // Plain configuration registers; a single event run clears the enable.
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            tbc_q     <= 16'h0000;
            period_q  <= 15'h0000;
            compare_q <= 16'h0000;
        end else if (ce_i) begin
            // A software write wins over the stop.
            if (wr_en & (idx == `IDX_TIME_BASE_CONTROL)) begin
                tbc_q <= pwdata_i[15:0] & `TBC_WRITE_MASK;
            end else if (single_done) begin
                tbc_q[`TBC_ON_BIT] <= 1'b0;
            end
            if (wr_en & (idx == `IDX_TIME_BASE_PERIOD)) begin
                period_q <= pwdata_i[14:0];
            end
            if (wr_en & (idx == `IDX_SPECIAL_EVENT_COMPARE)) begin
                compare_q <= pwdata_i[15:0];
            end
        end
    end

    // Prescaler, counter and direction.
    // Down counting occurs only in up/down modes.
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            presc_q   <= 6'h00;
            count_q   <= 15'h0000;
            dir_q     <= 1'b0;
            per_evt_q <= 1'b0;
        end else if (ce_i) begin
            per_evt_q <= 1'b0;
            // The prescaler restarts while stopped.
            if (~run) begin
                presc_q <= 6'h00;
            end else if (tick) begin
                presc_q <= 6'h00;
            end else begin
                presc_q <= presc_q + 6'h01;
            end
            // A count write wins over a tick.
            if (wr_en & (idx == `IDX_TIME_BASE_COUNT)) begin
                count_q <= pwdata_i[14:0];
            end else if (tick) begin
                case (mode)
                    `MODE_FREE_RUN, `MODE_SINGLE_EVENT: begin
                        // Mode 01 also stops at the period.
                        dir_q <= 1'b0;
                        if (at_period) begin
                            count_q   <= 15'h0000;
                            per_evt_q <= 1'b1;
                        end else begin
                            count_q <= count_q + 15'h0001;
                        end
                    end
                    default: begin
                        // Each value is visited once per turn, so a full
                        // cycle is twice the period. Mode 11 also flags
                        // arrival at the period, half a cycle from zero.
                        if (dir_q) begin
                            if (count_q <= 15'h0001) begin
                                count_q   <= 15'h0000;
                                dir_q     <= 1'b0;
                                per_evt_q <= 1'b1;
                            end else begin
                                count_q <= count_q - 15'h0001;
                            end
                        end else if (at_period) begin
                            dir_q     <= 1'b1;
                            count_q   <= (count_q == 15'h0000) ? 15'h0000 : count_q - 15'h0001;
                        end else begin
                            count_q   <= count_q + 15'h0001;
                            per_evt_q <= (mode == `MODE_UP_DOWN_DOUBLE) & (count_q + 15'h0001 == period_q);
                        end
                    end
                endcase
            end
        end
    end

    // Postscaler and special event trigger.
    // Both outputs are one-cycle pulses.
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            post_q      <= 4'h0;
            post_tick_q <= 1'b0;
            match_q     <= 1'b0;
            sev_q       <= 1'b0;
        end else if (ce_i) begin
            post_tick_q <= 1'b0;
            // Ticks on the last counted period event.
            if (per_evt_q) begin
                if (post_q == tbc_q[`TBC_POSTSCALE_MSB:`TBC_POSTSCALE_LSB]) begin
                    post_q      <= 4'h0;
                    post_tick_q <= 1'b1;
                end else begin
                    post_q <= post_q + 4'h1;
                end
            end
            // Fires on the first match cycle only,
            // and only while the time base is on.
            match_q <= match_now;
            sev_q   <= match_now & ~match_q & tbc_q[`TBC_ON_BIT];
        end
    end

endmodule
`default_nettype wire

// ==== hw/README_none.v ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== verification/motor_pwm_timebase_lock_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "motor_pwm_timebase_lock_consts.vh"
module motor_pwm_timebase_lock_checker (
    input wire        mclk_i,
    input wire        rst_i,
    input wire        ce_i,
    input wire        psel_i,
    input wire        penable_i,
    input wire        pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] prdata_o,
    input wire        pready_o,
    input wire        write_lock_config_i,
    input wire        count_direction_o,
    input wire [14:0] count_value_o,
    input wire        special_event_o,
    input wire        postscale_tick_o,
    input wire [15:0] fault_a_control_o,
    input wire [15:0] fault_b_control_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    wire        done  = psel_i && penable_i && pready_o && ce_i;
    wire        setup = psel_i && !penable_i && ce_i && !pwrite_i;
    wire        wr_ok = done && pwrite_i;
    wire        fa_wr = wr_ok && paddr_i == 12'h014;
    wire        fb_wr = wr_ok && paddr_i == 12'h018;
    reg  [2:0]  cfg_q;
    reg         first_q;
    reg         open_q;
    reg  [15:0] cmp_q;
    // The lock input passes a two-flop synchroniser, so only a level held three samples is trusted.
    wire        locked = &cfg_q;
    wire        free   = ~|cfg_q;
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_q   <= 3'h7;
            first_q <= 1'b0;
            open_q  <= 1'b0;
            cmp_q   <= 16'h0000;
        end else begin
            cfg_q <= {cfg_q[1:0], write_lock_config_i};
            if (done) begin
                first_q <= wr_ok && paddr_i == 12'h01C && pwdata_i[15:0] == `KEY_FIRST;
                open_q  <= wr_ok && paddr_i == 12'h01C && first_q && pwdata_i[15:0] == `KEY_SECOND;
            end
            if (wr_ok && paddr_i == 12'h00C) begin
                cmp_q <= pwdata_i[15:0];
            end
        end
    end
    blocked_write_a: assert property (fa_wr && locked && !open_q |=> $stable(fault_a_control_o))
        else $error("protected write took effect while locked");
    unlocked_write_a: assert property (fa_wr && (open_q || free) |=>
        {16'h0000, fault_a_control_o} == ($past(pwdata_i) & {16'h0000, `FAULT_WRITE_MASK}))
        else $error("unlocked write to fault a not applied");
    free_write_a: assert property (fb_wr && free |=>
        {16'h0000, fault_b_control_o} == ($past(pwdata_i) & {16'h0000, `FAULT_WRITE_MASK}))
        else $error("unprotected write to fault b not applied");
    period_top_a: assert property (setup && paddr_i == 12'h008 |=> prdata_o[15] == 1'b0)
        else $error("period bit 15 read as one");
    count_read_a: assert property (setup && paddr_i == 12'h004 |=>
        prdata_o[15:0] == {$past(count_direction_o), $past(count_value_o)})
        else $error("count register read differs from live count");
    fault_reset_a: assert property ($fell(rst_i) |->
        fault_a_control_o == `FAULT_RESET && fault_b_control_o == `FAULT_RESET)
        else $error("fault registers not at reset value");
    trig_pulse_a: assert property ($rose(special_event_o) |=> !special_event_o)
        else $error("special event longer than one cycle");
    trig_match_a: assert property (special_event_o |->
        {$past(count_direction_o), $past(count_value_o)} == cmp_q)
        else $error("special event without compare match");
    cover property (fa_wr && open_q);
    cover property (special_event_o);
    cover property (postscale_tick_o);
endmodule
bind motor_pwm_timebase_lock motor_pwm_timebase_lock_checker motor_pwm_timebase_lock_checker_inst (
    .mclk_i, .rst_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .write_lock_config_i, .count_direction_o, .count_value_o, .special_event_o, .postscale_tick_o,
    .fault_a_control_o, .fault_b_control_o
);
`default_nettype wire

// ==== verification/gate_driver_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module gate_driver_model (
    input  wire logic       mclk_i,
    input  wire logic [2:0] high_pin_enable_i,
    input  wire logic [2:0] low_pin_enable_i,
    output logic      [5:0] owned_o,
    output logic      [5:0] pin_o
);
    logic flip_q = 1'b0;
    always @(posedge mclk_i) begin
        flip_q <= ~flip_q;
    end
    assign owned_o = {high_pin_enable_i, low_pin_enable_i};
    // A released pin floats, so it shows a changing level instead of the last driven one.
    assign pin_o = ~owned_o & {6{flip_q}};
endmodule
`default_nettype wire

// ==== verification/motor_pwm_timebase_lock_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module motor_pwm_timebase_lock_tb_top;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        lock_cfg = 1'b1;
    logic        strap = 1'b1;
    logic        idle = 1'b0;
    logic        ce = 1'b1;
    logic [31:0] rd;
    logic        err;
    logic [14:0] save;
    logic        seen;
    wire  [31:0] prdata;
    wire         pready, pslverr, dir, pev, pst, sev;
    wire  [14:0] cnt;
    wire  [2:0]  pair, hen, len;
    wire  [15:0] fa, fb;
    wire  [5:0]  owned;
    wire  [2:0]  pulses = {sev, pst, pev};
    int          num_errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    always #4 mclk = ~mclk;
    motor_pwm_timebase_lock motor_pwm_timebase_lock_inst (
        .mclk_i(mclk), .rst_i(rst), .ce_i(ce), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .write_lock_config_i(lock_cfg), .pin_owner_at_reset_i(strap), .cpu_idle_i(idle),
        .count_direction_o(dir), .count_value_o(cnt), .period_event_o(pev), .postscale_tick_o(pst),
        .special_event_o(sev), .pair_independent_o(pair), .high_pin_enable_o(hen), .low_pin_enable_o(len),
        .fault_a_control_o(fa), .fault_b_control_o(fb)
    );
    gate_driver_model gate_driver_model_inst (
        .mclk_i(mclk), .high_pin_enable_i(hen), .low_pin_enable_i(len), .owned_o(owned), .pin_o()
    );
    task automatic chk(input string name, input logic [31:0] seen_v, input logic [31:0] exp);
        samples_checked++;
        if (seen_v !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen_v);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [15:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 16'h0000);
        chk(n, rd, exp);
    endtask
    task automatic unlock;
        wr(12'h01C, 16'hABCD);
        wr(12'h01C, 16'h4321);
    endtask
    task automatic do_reset(input logic s);
        @(posedge mclk);
        strap <= s;
        rst <= 1'b1;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask
    task automatic run(input logic [15:0] per, input logic [15:0] ctl);
        wr(12'h000, 16'h0000);
        wr(12'h004, 16'h0000);
        wr(12'h008, per);
        wr(12'h000, ctl);
    endtask
    task automatic gap(input int s, input int exp);
        int n;
        n = 0;
        do @(posedge mclk); while (pulses[s] !== 1'b1);
        do begin
            @(posedge mclk);
            n++;
        end while (pulses[s] !== 1'b1);
        chk("gap", n, exp);
    endtask
    task automatic end_of_test;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            num_errors++;
            end_of_test();
        end
    end
    initial begin
        do_reset(1'b1);
        chk("owned", owned, 32'h00);
        do_reset(1'b0);
        chk("owned", owned, 32'h3F);
        rchk("fault_a", 12'h014, 32'h0007);
        rchk("fault_b", 12'h018, 32'h0007);
        wr(12'h014, 16'h0000);
        rchk("fault_a", 12'h014, 32'h0007);
        unlock();
        wr(12'h014, 16'h0000);
        rchk("fault_a", 12'h014, 32'h0000);
        wr(12'h018, 16'h0000);
        rchk("fault_b", 12'h018, 32'h0007);
        unlock();
        rchk("key", 12'h01C, 32'h0000);
        wr(12'h018, 16'h0000);
        rchk("fault_b", 12'h018, 32'h0007);
        wr(12'h01C, 16'h4321);
        wr(12'h01C, 16'hABCD);
        wr(12'h018, 16'h0000);
        rchk("fault_b", 12'h018, 32'h0007);
        unlock();
        wr(12'h010, 16'h0700);
        @(posedge mclk);
        chk("owned", owned, 32'h00);
        chk("pair", pair, 32'h7);
        @(posedge mclk);
        lock_cfg <= 1'b0;
        repeat (4) @(posedge mclk);
        wr(12'h010, 16'h0077);
        wr(12'h018, 16'h0080);
        chk("owned", owned, 32'h3F);
        rchk("fault_b", 12'h018, 32'h0080);
        @(posedge mclk);
        lock_cfg <= 1'b1;
        wr(12'h008, 16'hFFFF);
        rchk("period", 12'h008, 32'h7FFF);
        wr(12'h004, 16'h0005);
        rchk("count", 12'h004, 32'h0005);
        rchk("unmapped", 12'h020, 32'h0000);
        chk("slverr", err, 32'h1);
        for (int i = 0; i < 4; i++) begin
            run(16'h0001, 16'h8000 | (16'(i) << 2));
            gap(0, (1 << (2 * i)) * 2);
        end
        run(16'h0001, 16'h80F0);
        gap(1, 32);
        run(16'h0001, 16'h8000);
        gap(1, 2);
        run(16'h0003, 16'h8002);
        gap(0, 6);
        run(16'h0003, 16'h8003);
        gap(0, 3);
        run(16'h0003, 16'h8001);
        repeat (20) @(posedge mclk);
        rchk("ctl", 12'h000, 32'h0001);
        chk("cnt", cnt, 32'h0);
        @(posedge mclk);
        idle <= 1'b1;
        run(16'h7FFF, 16'hA000);
        save = cnt;
        repeat (10) @(posedge mclk);
        chk("halt", cnt, save);
        idle <= 1'b0;
        repeat (10) @(posedge mclk);
        chk("resume", cnt != save, 32'h1);
        ce <= 1'b0;
        @(posedge mclk);
        save = cnt;
        repeat (10) @(posedge mclk);
        chk("freeze", cnt, save);
        ce <= 1'b1;
        wr(12'h00C, 16'h0002);
        run(16'h0005, 16'h8000);
        gap(2, 6);
        wr(12'h00C, 16'h8002);
        run(16'h0005, 16'h8000);
        seen = 1'b0;
        repeat (40) begin
            @(posedge mclk);
            seen = seen | sev;
        end
        chk("sev", seen, 32'h0);
        run(16'h0005, 16'h8002);
        gap(2, 10);
        end_of_test();
    end
endmodule
`default_nettype wire
